// File: src/afl_regs.vh
`ifndef AFL_REGS_VH
`define AFL_REGS_VH

// ==========================================
// command and error codes
`define AFL_CMD_WR_AFI 8'h27
`define AFL_CMD_LK_AFI 8'h28
`define AFL_CMD_WR_DSF 8'h29
`define AFL_CMD_LK_DSF 8'h2A
`define AFL_ERR_LOCK_AGAIN 8'h11
`define AFL_ERR_WR_LOCKED 8'h12
`define AFL_ERR_WR_FAIL 8'h13
`define AFL_ERR_LK_FAIL 8'h14
`define AFL_RSP_OK 8'h00
`define AFL_RSP_ERR 8'h01
`define AFL_FLAG_ADDR 5

// ==========================================
// crc16 and frame lengths in bits
`define AFL_CRC_POLY 16'h8408
`define AFL_CRC_INIT 16'hFFFF
`define AFL_CRC_GOOD 16'hF0B8
`define AFL_LEN_BASE 8'h20
`define AFL_LEN_UID 8'h40
`define AFL_LEN_VAL 8'h08

// ==========================================
// timing
`define AFL_CLK_NS 20
`define AFL_NOMINAL_RESPONSE_DELAY_NS 320900
`define AFL_SLOT_NS 302000
`define AFL_SLOTS 18
`define AFL_PROG_CYC ((`AFL_NOMINAL_RESPONSE_DELAY_NS + `AFL_SLOTS * `AFL_SLOT_NS + `AFL_CLK_NS - 1) / `AFL_CLK_NS)
`define AFL_RESP_BIT_CYC 8

// ==========================================
// register offsets, fields, reset values
`define AFL_REG_CTRL 8'h00
`define AFL_REG_STATUS 8'h04
`define AFL_REG_IRQ_STAT 8'h08
`define AFL_REG_IRQ_EN 8'h0C
`define AFL_REG_IRQ_CLR 8'h10
`define AFL_CTRL_BUSY_MODE 0
`define AFL_CTRL_RST 1'b1
`define AFL_IRQ_DONE 0
`define AFL_IRQ_ERR 1
`define AFL_IRQ_DROP 2
`define AFL_IRQ_EN_RST 3'h0
`define AFL_ID_RST 8'h00

`endif

// File: src/afl_rf_id_lock.v
`timescale 1ns/1ps
`include "afl_regs.vh"

module afl_rf_id_lock #(
  parameter [19:0] PROG_CYC = `AFL_PROG_CYC,
  parameter [7:0] RESP_BIT_CYC = `AFL_RESP_BIT_CYC
) (
  // clock, reset, enable
  input wire core_clk,
  input wire arst_n,
  input wire clk_en,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // demodulated request link
  input wire rf_clk,
  input wire rf_data,
  input wire rf_frame,
  // reply link
  output reg resp_frame,
  output reg resp_bit,
  // nonvolatile program result
  input wire nv_fail,
  // activity pin, open drain
  output reg rf_activity_pin_out,
  output reg rf_activity_pin_oe,
  // interrupt
  output reg irq
);

  // ==========================================
  // states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RECV = 4'b0010;
  localparam [3:0] ST_PROG = 4'b0100;
  localparam [3:0] ST_RESP = 4'b1000;

  // ==========================================
  // crc over one byte, lsb first
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] t;
    begin
      t = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (t[0] ^ d[i])
          t = {1'b0, t[15:1]} ^ `AFL_CRC_POLY;
        else
          t = {1'b0, t[15:1]};
      end
      crc_byte = t;
    end
  endfunction

  // ==========================================
  // storage and control
  reg [3:0] state;
  reg [2:0] clk_s;
  reg [1:0] dat_s;
  reg [2:0] frm_s;
  reg [7:0] bit_cnt;
  reg [15:0] rx_crc;
  reg [23:0] rx_sr;
  reg [7:0] hdr_flags;
  reg [7:0] hdr_cmd;
  reg [7:0] app_family_id;
  reg [7:0] data_storage_format_id;
  reg afi_locked;
  reg dsf_locked;
  reg op_lock;
  reg op_dsf;
  reg op_nv;
  reg [7:0] op_val;
  reg [7:0] op_err;
  reg [19:0] prog_cnt;
  reg [31:0] tx_sr;
  reg [5:0] tx_left;
  reg [7:0] tx_cnt;
  reg ctrl_busy_mode;
  reg [2:0] irq_stat;
  reg [2:0] irq_en;
  reg [2:0] ev;

  // ==========================================
  // input synchronisers and edges
  wire rf_clk_rise = clk_s[1] & ~clk_s[2];
  wire frm_rise = frm_s[1] & ~frm_s[2];
  wire frm_fall = ~frm_s[1] & frm_s[2];
  wire rx_bit = dat_s[1];

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_s <= 3'h0;
      dat_s <= 2'h0;
      frm_s <= 3'h0;
    end else if (clk_en) begin
      clk_s <= {clk_s[1:0], rf_clk};
      dat_s <= {dat_s[0], rf_data};
      frm_s <= {frm_s[1:0], rf_frame};
    end
  end

  // ==========================================
  // request decode
  wire is_wr_afi = (hdr_cmd == `AFL_CMD_WR_AFI);
  wire is_lk_afi = (hdr_cmd == `AFL_CMD_LK_AFI);
  wire is_wr_dsf = (hdr_cmd == `AFL_CMD_WR_DSF);
  wire is_lk_dsf = (hdr_cmd == `AFL_CMD_LK_DSF);
  wire is_write = is_wr_afi | is_wr_dsf;
  wire is_ours = is_write | is_lk_afi | is_lk_dsf;
  // option flag is not part of the check
  wire [7:0] exp_len = `AFL_LEN_BASE
    + (hdr_flags[`AFL_FLAG_ADDR] ? `AFL_LEN_UID : 8'h00)
    + (is_write ? `AFL_LEN_VAL : 8'h00);
  wire crc_ok = (rx_crc == `AFL_CRC_GOOD);
  wire len_ok = (bit_cnt == exp_len);
  wire tgt_dsf = is_wr_dsf | is_lk_dsf;
  wire tgt_locked = tgt_dsf ? dsf_locked : afi_locked;

  // ==========================================
  // error code chosen at end of request
  reg [7:0] next_err;
  always @* begin
    next_err = 8'h00;
    if (tgt_locked) begin
      if (is_write)
        next_err = `AFL_ERR_WR_LOCKED;
      else
        next_err = `AFL_ERR_LOCK_AGAIN;
    end
  end

  // ==========================================
  // final error code after the program cycle
  reg [7:0] fin_err;
  always @* begin
    fin_err = op_err;
    if (op_nv && nv_fail) begin
      if (op_lock)
        fin_err = `AFL_ERR_LK_FAIL;
      else
        fin_err = `AFL_ERR_WR_FAIL;
    end
  end

  // ==========================================
  // reply frame
  wire [15:0] crc_ok_rsp = crc_byte(`AFL_CRC_INIT, `AFL_RSP_OK);
  wire [15:0] crc_err_1 = crc_byte(`AFL_CRC_INIT, `AFL_RSP_ERR);
  wire [15:0] crc_err_rsp = crc_byte(crc_err_1, fin_err);

  // ==========================================
  // main sequencer
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 8'h00;
      rx_crc <= `AFL_CRC_INIT;
      rx_sr <= 24'h0;
      hdr_flags <= 8'h00;
      hdr_cmd <= 8'h00;
      app_family_id <= `AFL_ID_RST;
      data_storage_format_id <= `AFL_ID_RST;
      afi_locked <= 1'b0;
      dsf_locked <= 1'b0;
      op_lock <= 1'b0;
      op_dsf <= 1'b0;
      op_nv <= 1'b0;
      op_val <= 8'h00;
      op_err <= 8'h00;
      prog_cnt <= 20'h0;
      tx_sr <= 32'h0;
      tx_left <= 6'h0;
      tx_cnt <= 8'h00;
      resp_frame <= 1'b0;
      resp_bit <= 1'b0;
      ev <= 3'h0;
    end else if (clk_en) begin
      ev <= 3'h0;
      case (state)
        ST_IDLE: begin
          if (frm_rise) begin
            state <= ST_RECV;
            bit_cnt <= 8'h00;
            rx_crc <= `AFL_CRC_INIT;
          end
        end
        ST_RECV: begin
          if (bit_cnt == 8'h10) begin
            hdr_flags <= rx_sr[15:8];
            hdr_cmd <= rx_sr[23:16];
          end
          if (frm_fall) begin
            if (!crc_ok) begin
              state <= ST_IDLE;
              ev[`AFL_IRQ_DROP] <= 1'b1;
            end else if (is_ours && len_ok) begin
              state <= ST_PROG;
              prog_cnt <= PROG_CYC - 20'h1;
              op_lock <= ~is_write;
              op_dsf <= tgt_dsf;
              op_val <= rx_sr[7:0];
              op_err <= next_err;
              op_nv <= (next_err == 8'h00);
            end else begin
              state <= ST_IDLE;
            end
          end else if (rf_clk_rise && frm_s[1]) begin
            rx_sr <= {rx_bit, rx_sr[23:1]};
            if (bit_cnt != 8'hFF)
              bit_cnt <= bit_cnt + 8'h01;
            if (rx_crc[0] ^ rx_bit)
              rx_crc <= {1'b0, rx_crc[15:1]} ^ `AFL_CRC_POLY;
            else
              rx_crc <= {1'b0, rx_crc[15:1]};
          end
        end
        ST_PROG: begin
          if (prog_cnt != 20'h0) begin
            prog_cnt <= prog_cnt - 20'h1;
          end else begin
            if (op_nv && !nv_fail) begin
              if (!op_lock && !op_dsf)
                app_family_id <= op_val;
              if (op_lock && !op_dsf)
                afi_locked <= 1'b1;
              if (!op_lock && op_dsf)
                data_storage_format_id <= op_val;
              if (op_lock && op_dsf)
                dsf_locked <= 1'b1;
            end
            op_err <= fin_err;
            if (fin_err == 8'h00) begin
              tx_sr <= {8'h00, ~crc_ok_rsp, `AFL_RSP_OK};
              tx_left <= 6'd24;
            end else begin
              tx_sr <= {~crc_err_rsp, fin_err, `AFL_RSP_ERR};
              tx_left <= 6'd32;
            end
            tx_cnt <= 8'h00;
            state <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (tx_cnt == 8'h00) begin
            if (tx_left == 6'h0) begin
              resp_frame <= 1'b0;
              resp_bit <= 1'b0;
              state <= ST_IDLE;
              if (op_err == 8'h00)
                ev[`AFL_IRQ_DONE] <= 1'b1;
              else
                ev[`AFL_IRQ_ERR] <= 1'b1;
            end else begin
              resp_frame <= 1'b1;
              resp_bit <= tx_sr[0];
              tx_sr <= {1'b0, tx_sr[31:1]};
              tx_left <= tx_left - 6'h1;
              tx_cnt <= RESP_BIT_CYC - 8'h01;
            end
          end else begin
            tx_cnt <= tx_cnt - 8'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // activity pin
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rf_activity_pin_out <= 1'b0;
      rf_activity_pin_oe <= 1'b0;
    end else if (clk_en) begin
      rf_activity_pin_out <= 1'b0;
      if (ctrl_busy_mode)
        rf_activity_pin_oe <= (state != ST_IDLE);
      else
        rf_activity_pin_oe <= (state == ST_PROG) && op_nv;
    end
  end

  // ==========================================
  // registers and interrupt
  wire reg_wr_ctrl = reg_wr && (reg_addr == `AFL_REG_CTRL);
  wire reg_wr_en = reg_wr && (reg_addr == `AFL_REG_IRQ_EN);
  wire reg_wr_clr = reg_wr && (reg_addr == `AFL_REG_IRQ_CLR);
  wire [2:0] clr_mask = reg_wr_clr ? reg_wdata[2:0] : 3'h0;

  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0;
    case (reg_addr)
      `AFL_REG_CTRL: next_rdata[`AFL_CTRL_BUSY_MODE] = ctrl_busy_mode;
      `AFL_REG_STATUS: next_rdata = {8'h00, state, 2'b00, dsf_locked, afi_locked,
        data_storage_format_id, app_family_id};
      `AFL_REG_IRQ_STAT: next_rdata[2:0] = irq_stat;
      `AFL_REG_IRQ_EN: next_rdata[2:0] = irq_en;
      default: next_rdata = 32'h0;
    endcase
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0;
      ctrl_busy_mode <= `AFL_CTRL_RST;
      irq_en <= `AFL_IRQ_EN_RST;
      irq_stat <= 3'h0;
      irq <= 1'b0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0;
      if (reg_wr_ctrl)
        ctrl_busy_mode <= reg_wdata[`AFL_CTRL_BUSY_MODE];
      if (reg_wr_en)
        irq_en <= reg_wdata[2:0];
      irq_stat <= (irq_stat & ~clr_mask) | ev;
      irq <= |(irq_stat & irq_en);
    end
  end

endmodule // afl_rf_id_lock

// File: dv/afl_rf_id_lock_props.sv
`timescale 1ns/1ps
// ======
// port checker
module afl_rf_id_lock_props #(
  parameter [19:0] PROG_CYC = 20'd200,
  parameter [7:0] RESP_BIT_CYC = 8'd8
) (
  input wire core_clk,
  input wire arst_n,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire rf_clk,
  input wire rf_data,
  input wire rf_frame,
  input wire resp_frame,
  input wire resp_bit,
  input wire nv_fail,
  input wire rf_activity_pin_out,
  input wire rf_activity_pin_oe,
  input wire irq
);
  reg busy;
  reg first;
  reg [19:0] gap;
  reg [15:0] cnt;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b1;
      first <= 1'b0;
      gap <= 20'h0;
      cnt <= 16'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h00) busy <= reg_wdata[0];
      if (resp_frame && cnt == 16'h0) first <= resp_bit;
      cnt <= resp_frame ? cnt + 16'h1 : 16'h0;
      gap <= rf_frame ? 20'h0 : (gap == 20'hFFFFF ? gap : gap + 20'h1);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_pin_pulls_low: assert property (rf_activity_pin_out == 1'b0)
    else $error("pin value not low");
  a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  a_reply_length: assert property ($fell(resp_frame) |->
    cnt == (first ? 16'd32 : 16'd24) * RESP_BIT_CYC)
    else $error("reply length wrong");
  a_reply_bit_hold: assert property (resp_frame && cnt % RESP_BIT_CYC != 0 |-> $stable(resp_bit))
    else $error("reply bit moved");
  a_busy_reply: assert property (busy && resp_frame && $past(resp_frame, 2) |->
    rf_activity_pin_oe) else $error("busy pin free in reply");
  a_wip_reply: assert property (!busy && resp_frame && $past(resp_frame, 2) |->
    !rf_activity_pin_oe) else $error("wip pin low in reply");
  a_reply_after_prog: assert property ($rose(resp_frame) |-> gap >= PROG_CYC)
    else $error("reply too early");
  a_busy_receive: assert property (busy && rf_frame && $past(rf_frame, 6) |->
    rf_activity_pin_oe) else $error("busy pin free in request");
  c_ok: cover property ($fell(resp_frame) && !first);
  c_err: cover property ($fell(resp_frame) && first);
  c_irq: cover property ($rose(irq));
endmodule // afl_rf_id_lock_props

bind afl_rf_id_lock afl_rf_id_lock_props #(.PROG_CYC(PROG_CYC), .RESP_BIT_CYC(RESP_BIT_CYC))
  props_i (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rf_clk(rf_clk), .rf_data(rf_data), .rf_frame(rf_frame), .resp_frame(resp_frame),
  .resp_bit(resp_bit), .nv_fail(nv_fail), .rf_activity_pin_out(rf_activity_pin_out),
  .rf_activity_pin_oe(rf_activity_pin_oe), .irq(irq));

// File: dv/afl_reader.sv
`timescale 1ns/1ps
// ======
// reader model
module afl_reader #(
  parameter int WAIT_CYC = 400,
  parameter int BIT_CYC = 8
) (
  // sampling clock
  input wire core_clk,
  // request link
  output reg rf_clk,
  output reg rf_data,
  output reg rf_frame,
  // reply link
  input wire resp_frame,
  input wire resp_bit
);
  initial begin
    rf_clk = 1'b0;
    rf_data = 1'b0;
    rf_frame = 1'b0;
  end
  function automatic [15:0] crc(input [111:0] v, input int n);
    int i;
    crc = 16'hFFFF;
    for (i = 0; i < n; i++) crc = (crc[0] ^ v[i]) ? (crc >> 1) ^ 16'h8408 : crc >> 1;
    crc = ~crc;
  endfunction
  task automatic xfer(input [111:0] req, input int n, input bit bad, output [31:0] rsp,
    output int nb);
    logic [111:0] f;
    int i;
    f = req | ({96'h0, crc(req, n) ^ {15'h0, bad}} << n);
    rsp = 32'h0;
    nb = 0;
    #7 rf_frame <= 1'b1;
    for (i = 0; i < n + 16; i++) begin
      #40 rf_data <= f[i];
      #40 rf_clk <= 1'b1;
      #80 rf_clk <= 1'b0;
    end
    #160 rf_frame <= 1'b0;
    rf_data <= ~rf_data;
    i = 0;
    while (!resp_frame && i < WAIT_CYC) begin
      @(negedge core_clk);
      i++;
    end
    i = 0;
    while (resp_frame && i < WAIT_CYC) begin
      if (i % BIT_CYC == BIT_CYC / 2 && nb < 32) begin
        rsp[nb] = resp_bit;
        nb++;
      end
      i++;
      @(negedge core_clk);
    end
  endtask
endmodule // afl_reader

// File: dv/afl_rf_id_lock_test.sv
`timescale 1ns/1ps
`include "afl_regs.vh"
// ======
// bench top
module afl_rf_id_lock_test;
  reg core_clk, arst_n, clk_en, reg_wr, reg_rd, nv_fail, oe_seen, lka, lkd;
  reg [7:0] reg_addr, application_family_id, dsf;
  reg [31:0] reg_wdata;
  wire [31:0] reg_rdata;
  wire rf_clk, rf_data, rf_frame, resp_frame, resp_bit, pin_out, pin_oe, irq;
  int error_cnt, checks_done;
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (pin_oe) oe_seen <= 1'b1;
  afl_rf_id_lock #(.PROG_CYC(20'd200), .RESP_BIT_CYC(8'd8)) afl_rf_id_lock_i (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rf_clk(rf_clk), .rf_data(rf_data), .rf_frame(rf_frame), .resp_frame(resp_frame),
    .resp_bit(resp_bit), .nv_fail(nv_fail), .rf_activity_pin_out(pin_out),
    .rf_activity_pin_oe(pin_oe), .irq(irq));
  afl_reader #(.WAIT_CYC(400), .BIT_CYC(8)) afl_reader_i (.core_clk(core_clk),
    .rf_clk(rf_clk), .rf_data(rf_data), .rf_frame(rf_frame), .resp_frame(resp_frame),
    .resp_bit(resp_bit));
  task chk(input string what, input [31:0] exp, input [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] exp, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(what, exp, reg_rdata);
  endtask
  // code 00 ok reply, FF no reply, else error code
  task cmd(input [7:0] fl, input [7:0] op, input [7:0] val, input bit bad, input [7:0] code);
    logic [111:0] r;
    logic [31:0] rsp;
    int nb, n;
    r = {96'h0, op, fl};
    n = 16;
    if (fl[5]) r = r | ({48'h0, 64'h0123456789ABCDEF} << 16);
    if (fl[5]) n = 80;
    if (op == 8'h27 || op == 8'h29) r = r | ({104'h0, val} << n);
    if (op == 8'h27 || op == 8'h29) n += 8;
    afl_reader_i.xfer(r, n, bad, rsp, nb);
    if (resp_frame || (code != 8'hFF && nb == 0)) begin
      chk("reply timeout", 32'd0, 32'd1);
      summarize;
    end
    if (code == 8'hFF) chk("reply bits", 32'd0, nb);
    else if (code == 8'h00) begin
      chk("reply bits", 32'd24, nb);
      chk("ok reply", {8'h0, afl_reader_i.crc(112'h0, 8), 8'h00}, rsp);
    end else begin
      chk("reply bits", 32'd32, nb);
      chk("err reply", {afl_reader_i.crc({96'h0, code, 8'h01}, 16), code, 8'h01}, rsp);
    end
    rd(`AFL_REG_STATUS, {8'h0, 4'h1, 2'h0, lkd, lka, dsf, application_family_id}, "status");
  endtask
  task t_regs;
    rd(`AFL_REG_CTRL, 32'h1, "ctrl");
    rd(`AFL_REG_STATUS, 32'h0010_0000, "status");
    rd(8'h14, 32'h0, "unmapped");
    wr(`AFL_REG_IRQ_EN, 32'h7);
    rd(`AFL_REG_IRQ_EN, 32'h7, "irq_en");
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(`AFL_REG_IRQ_EN, 32'h0);
    clk_en <= 1'b1;
    rd(`AFL_REG_IRQ_EN, 32'h7, "irq_en frozen");
  endtask
  task t_write;
    application_family_id = 8'h5A;
    cmd(8'h42, `AFL_CMD_WR_AFI, 8'h5A, 0, 8'h00);
    wr(`AFL_REG_CTRL, 32'h0);
    dsf = 8'hC3;
    oe_seen = 1'b0;
    cmd(8'h62, `AFL_CMD_WR_DSF, 8'hC3, 0, 8'h00);
    chk("wip pin", 32'd1, oe_seen);
  endtask
  task t_fail;
    @(posedge core_clk);
    nv_fail <= 1'b1;
    cmd(8'h02, `AFL_CMD_WR_AFI, 8'h11, 0, `AFL_ERR_WR_FAIL);
    cmd(8'h02, `AFL_CMD_LK_DSF, 8'h00, 0, `AFL_ERR_LK_FAIL);
    @(posedge core_clk);
    nv_fail <= 1'b0;
  endtask
  task t_lock;
    lka = 1'b1;
    cmd(8'h02, `AFL_CMD_LK_AFI, 8'h00, 0, 8'h00);
    oe_seen = 1'b0;
    cmd(8'h02, `AFL_CMD_WR_AFI, 8'h99, 0, `AFL_ERR_WR_LOCKED);
    chk("wip pin idle", 32'd0, oe_seen);
    cmd(8'h02, `AFL_CMD_LK_AFI, 8'h00, 0, `AFL_ERR_LOCK_AGAIN);
    lkd = 1'b1;
    cmd(8'h22, `AFL_CMD_LK_DSF, 8'h00, 0, 8'h00);
    cmd(8'h02, `AFL_CMD_WR_DSF, 8'h01, 0, `AFL_ERR_WR_LOCKED);
    cmd(8'h02, `AFL_CMD_LK_DSF, 8'h00, 0, `AFL_ERR_LOCK_AGAIN);
  endtask
  task t_crc;
    cmd(8'h02, `AFL_CMD_WR_AFI, 8'h77, 1, 8'hFF);
    rd(`AFL_REG_IRQ_STAT, 32'h7, "irq_stat");
    chk("irq", 32'd1, irq);
    wr(`AFL_REG_IRQ_EN, 32'h0);
    repeat (2) @(negedge core_clk);
    chk("irq masked", 32'd0, irq);
    wr(`AFL_REG_IRQ_CLR, 32'h7);
    wr(`AFL_REG_IRQ_EN, 32'h7);
    rd(`AFL_REG_IRQ_STAT, 32'h0, "irq cleared");
    chk("irq low", 32'd0, irq);
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {core_clk, arst_n, reg_wr, reg_rd, nv_fail, oe_seen, lka, lkd} = 8'h00;
    clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    application_family_id = 8'h00;
    dsf = 8'h00;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs;
    t_write;
    t_fail;
    t_lock;
    t_crc;
    summarize;
  end
endmodule // afl_rf_id_lock_test
